// file: core/jir_core.sv
// Test-port instruction register, opcode decode and data path select
`timescale 1ns/1ps

module jir_core (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tdi,
  input wire jir_pkg::jir_tap_type tap_next,
  input wire logic bsr_so,
  input wire logic id_so,
  output logic tdo_q,
  output logic tdo_oe_q,
  output logic [jir_pkg::IR_W-1:0] ir_current_q,
  output logic sel_bsr_q,
  output logic sel_id_q,
  output logic sel_byp_q,
  output logic bsr_capture_q,
  output logic bsr_shift_q,
  output logic bsr_update_q,
  output logic pin_latch_q,
  output logic pin_highz_q,
  output logic sys_pin_latch_q,
  output logic sys_pin_highz_q
);
  import jir_pkg::*;

  // ----------------------------------------------------------------
  // State of the test clock domain
  // ----------------------------------------------------------------
  typedef struct packed {
    jir_tap_type st;         // Controller state now in force
    logic [IR_W-1:0] ir_sr;  // Instruction shift stage
    logic [IR_W-1:0] ir_cur; // Current instruction
    logic byp;               // Bypass bit
    logic sel_bsr;           // Boundary chain in path
    logic sel_id;            // Identification register in path
    logic sel_byp;           // Bypass bit in path
    logic pin_latch;         // Pins follow boundary latches
    logic pin_highz;         // All outputs floated
    logic bsr_cap;           // Boundary chain capture this state
    logic bsr_shift;         // Boundary chain shift this state
    logic bsr_upd;           // Boundary latch update this state
  } jir_tck_state_type;

  jir_tck_state_type r_q;
  jir_tck_state_type r_d;
  logic rst_tck;      // Either reset clears the test domain
  logic tdo_d;        // Serial output source
  logic tdo_oe_d;     // Serial output enable
  logic [1:0] sys_sync; // Pin modes seen by the system clock

  // Pin reset and system reset both act without the clock
  assign rst_tck = sys_rst | ~trst_n;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_d = r_q;
    r_d.st = tap_next;
    // Work done at the edge that leaves the present state
    if (r_q.st == TAP_CAPTURE_IR) begin
      r_d.ir_sr = IR_CAPTURE_PATTERN;
    end else if (r_q.st == TAP_SHIFT_IR) begin
      // Low bit leaves first so the 01 of the pattern shows first
      r_d.ir_sr = {tdi, r_q.ir_sr[IR_W-1:1]};
    end
    // Previous instruction stays until the update state
    if (r_q.st == TAP_UPDATE_IR) begin
      r_d.ir_cur = r_q.ir_sr;
    end else if (r_q.st == TAP_TLR) begin
      r_d.ir_cur = IR_RESET_VALUE;
    end
    // Bypass bit moves only while it is the chosen path
    if (r_q.sel_byp && r_q.st == TAP_CAPTURE_DR) begin
      r_d.byp = BYP_CAPTURE_VALUE;
    end else if (r_q.sel_byp && r_q.st == TAP_SHIFT_DR) begin
      r_d.byp = tdi;
    end
    // Decode of the instruction that will be current
    r_d.sel_bsr = 1'b0;
    r_d.sel_id = 1'b0;
    r_d.sel_byp = 1'b0;
    r_d.pin_latch = 1'b0;
    r_d.pin_highz = 1'b0;
    case (r_d.ir_cur)
      OP_EXTEST: begin
        r_d.sel_bsr = 1'b1;
        r_d.pin_latch = 1'b1;
      end
      OP_SAMPLE: begin
        r_d.sel_bsr = 1'b1;
      end
      OP_IDCODE: begin
        r_d.sel_id = 1'b1;
      end
      OP_HIGHZ: begin
        // Bypass keeps the chain short while outputs float
        r_d.sel_byp = 1'b1;
        r_d.pin_highz = 1'b1;
      end
      OP_CLAMP: begin
        r_d.sel_byp = 1'b1;
        r_d.pin_latch = 1'b1;
      end
      default: begin
        // Bypass and the reserved codes; reserved codes get no test mode
        r_d.sel_byp = 1'b1;
      end
    endcase
    // Boundary chain strobes, valid during the state entered next
    r_d.bsr_cap = r_d.sel_bsr && tap_next == TAP_CAPTURE_DR;
    r_d.bsr_shift = r_d.sel_bsr && tap_next == TAP_SHIFT_DR;
    r_d.bsr_upd = r_d.sel_bsr && tap_next == TAP_UPDATE_DR;
  end

  // ----------------------------------------------------------------
  // Test clock registers
  // ----------------------------------------------------------------
  always_ff @(posedge tck or posedge rst_tck) begin
    if (rst_tck) begin
      r_q <= '0;
      r_q.st <= TAP_TLR;
      r_q.ir_sr <= IR_RESET_VALUE;
      r_q.ir_cur <= IR_RESET_VALUE;
      r_q.sel_id <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------
  // Path source for the falling-edge output stage
  always_comb begin
    tdo_d = 1'b0;
    tdo_oe_d = 1'b0;
    if (r_q.st == TAP_SHIFT_IR) begin
      tdo_d = r_q.ir_sr[0];
      tdo_oe_d = 1'b1;
    end else if (r_q.st == TAP_SHIFT_DR) begin
      tdo_oe_d = 1'b1;
      if (r_q.sel_bsr) begin
        tdo_d = bsr_so;
      end else if (r_q.sel_id) begin
        tdo_d = id_so;
      end else begin
        tdo_d = r_q.byp;
      end
    end
  end

  // Falling edge gives the far end half a period of set-up
  always_ff @(negedge tck or posedge rst_tck) begin
    if (rst_tck) begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else begin
      tdo_q <= tdo_d;
      tdo_oe_q <= tdo_oe_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs and crossing to the system clock
  // ----------------------------------------------------------------
  assign ir_current_q = r_q.ir_cur;
  assign sel_bsr_q = r_q.sel_bsr;
  assign sel_id_q = r_q.sel_id;
  assign sel_byp_q = r_q.sel_byp;
  assign bsr_capture_q = r_q.bsr_cap;
  assign bsr_shift_q = r_q.bsr_shift;
  assign bsr_update_q = r_q.bsr_upd;
  assign pin_latch_q = r_q.pin_latch;
  assign pin_highz_q = r_q.pin_highz;

  // Modes are levels that change rarely, so two flops suffice
  jir_sync #(
    .W(2)
  ) u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .async_in({r_q.pin_latch, r_q.pin_highz}),
    .sync_q(sys_sync)
  );
  assign sys_pin_latch_q = sys_sync[1];
  assign sys_pin_highz_q = sys_sync[0];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge tck);
  endclocking
  default disable iff (rst_tck);

  sequence s_shift_ir;
    r_q.st == TAP_SHIFT_IR;
  endsequence

  sequence s_update_ir;
    r_q.st == TAP_UPDATE_IR;
  endsequence

  sequence s_capture_then_shift;
    r_q.st == TAP_CAPTURE_IR ##1 r_q.st == TAP_SHIFT_IR;
  endsequence

  a_ir_shift_in: assert property (
    s_shift_ir |=> r_q.ir_sr == {$past(tdi), $past(r_q.ir_sr[IR_W-1:1])})
    else $error("instruction shift stage did not shift");

  a_ir_held: assert property (
    (r_q.st != TAP_UPDATE_IR && r_q.st != TAP_TLR) |=> $stable(r_q.ir_cur))
    else $error("current instruction changed outside update");

  a_ir_update_load: assert property (
    s_update_ir |=> r_q.ir_cur == $past(r_q.ir_sr))
    else $error("update did not load the shifted instruction");

  a_capture_pattern: assert property (
    s_capture_then_shift |-> r_q.ir_sr == IR_CAPTURE_PATTERN && tdo_oe_d && tdo_d)
    else $error("capture pattern missing at start of shift");

  a_reset_idcode: assert property (
    r_q.st == TAP_TLR |=> r_q.ir_cur == OP_IDCODE ##0 sel_id_q)
    else $error("test reset did not select identification");

  a_bypass_zero: assert property (
    (r_q.st == TAP_CAPTURE_DR && r_q.sel_byp) |=> !r_q.byp)
    else $error("bypass bit did not capture zero");

  a_highz_pins: assert property (
    r_q.ir_cur == OP_HIGHZ |-> pin_highz_q && !pin_latch_q && sel_byp_q)
    else $error("high impedance decode wrong");

  a_clamp_path: assert property (
    r_q.ir_cur == OP_CLAMP |-> pin_latch_q && sel_byp_q && !sel_bsr_q)
    else $error("clamp decode wrong");

  a_extest_update: assert property (
    (r_q.st == TAP_UPDATE_DR && r_q.ir_cur == OP_EXTEST) |-> bsr_update_q && pin_latch_q)
    else $error("boundary update missing under external test");

  a_one_path: assert property (
    $onehot({sel_bsr_q, sel_id_q, sel_byp_q}))
    else $error("not exactly one data path selected");

  a_unselected_quiet: assert property (
    !sel_bsr_q |-> !bsr_capture_q && !bsr_shift_q && !bsr_update_q)
    else $error("boundary chain strobed while not selected");

  a_sample_capture: assert property (
    (r_q.st == TAP_CAPTURE_DR && r_q.ir_cur == OP_SAMPLE) |-> bsr_capture_q && !pin_latch_q)
    else $error("sample capture missing");

endmodule

// file: core/jir_sync.sv
// Two-stage level synchroniser into the system clock domain
`timescale 1ns/1ps

module jir_sync #(
  parameter int W = 2
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_q
);
  import jir_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] meta; // First stage, read only by the second
    logic [W-1:0] held; // Second stage, safe to use
  } jir_sync_state_type;

  jir_sync_state_type r_q;
  jir_sync_state_type r_d;

  // Width must be usable
  if (W < 1) begin : g_bad_width
    $error("jir_sync: W must be at least 1");
  end

  // Next state: plain shift through two stages
  always_comb begin
    r_d = r_q;
    r_d.meta = async_in;
    r_d.held = r_q.meta;
  end

  // Registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign sync_q = r_q.held;

endmodule

// file: shared/jir_pkg.sv
// Shared constants and types for the test-port instruction register block
package jir_pkg;

  // ----------------------------------------------------------------
  // Instruction register layout
  // ----------------------------------------------------------------
  localparam int IR_W = 6;                          // Instruction length in bits
  localparam logic [5:0] OP_EXTEST = 6'h00;         // Pins from boundary latches
  localparam logic [5:0] OP_SAMPLE = 6'h01;         // Sample and preload
  localparam logic [5:0] OP_IDCODE = 6'h02;         // Identification register
  localparam logic [5:0] OP_HIGHZ = 6'h03;          // All outputs floated
  localparam logic [5:0] OP_CLAMP = 6'h3e;          // Pins held, bypass in path
  localparam logic [5:0] OP_BYPASS = 6'h3f;         // Single-bit path
  localparam logic [5:0] IR_CAPTURE_PATTERN = 6'h2d; // Loaded at capture, low bits 01
  localparam logic [5:0] IR_RESET_VALUE = OP_IDCODE; // Instruction after test reset
  localparam logic BYP_CAPTURE_VALUE = 1'b0;        // Bypass bit captures zero

  // ----------------------------------------------------------------
  // Test access port controller states (driven by the outside controller)
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TAP_TLR        = 4'h0,
    TAP_IDLE       = 4'h1,
    TAP_SEL_DR     = 4'h3,
    TAP_CAPTURE_DR = 4'h2,
    TAP_SHIFT_DR   = 4'h6,
    TAP_EXIT1_DR   = 4'h7,
    TAP_PAUSE_DR   = 4'h5,
    TAP_EXIT2_DR   = 4'h4,
    TAP_UPDATE_DR  = 4'hc,
    TAP_SEL_IR     = 4'hd,
    TAP_CAPTURE_IR = 4'hf,
    TAP_SHIFT_IR   = 4'he,
    TAP_EXIT1_IR   = 4'ha,
    TAP_PAUSE_IR   = 4'hb,
    TAP_EXIT2_IR   = 4'h9,
    TAP_UPDATE_IR  = 4'h8
  } jir_tap_type;

endpackage

// file: tb/jir_tester.sv
// Tester model: makes the test clock and walks the port controller
`timescale 1ns/1ps

module jir_tester (
  output logic tck,
  output jir_pkg::jir_tap_type tap_next,
  output logic tdi,
  input wire logic tdo
);
  import jir_pkg::*;

  // Controller parked in reset, test input at its pull-up level
  initial begin
    tck = 1'b0;
    tap_next = TAP_TLR;
    tdi = 1'b1;
  end

  // Test clock, 15 ns, phase unrelated to the system clock
  always #7.5 tck = ~tck;

  // One step, launched at a rising edge; idle input rests high
  task automatic go(input jir_tap_type st, input logic b = 1'b1);
    tap_next <= st;
    tdi <= b;
    @(posedge tck);
  endtask

  // Capture, then shift the opcode in from its low bit
  task automatic ir_shift(input logic [5:0] op, output logic [5:0] cap);
    @(posedge tck);
    go(TAP_IDLE);
    go(TAP_SEL_DR);
    go(TAP_SEL_IR);
    go(TAP_CAPTURE_IR);
    go(TAP_SHIFT_IR);
    for (int i = 0; i < 6; i++) begin
      // Last bit shifts on the edge that leaves the shift state
      if (i == 5) begin
        go(TAP_EXIT1_IR, op[i]);
      end else begin
        go(TAP_SHIFT_IR, op[i]);
      end
      cap[i] = tdo;
    end
  endtask

  // Idle edges after the update let the new decode settle
  task automatic ir_update();
    go(TAP_UPDATE_IR);
    go(TAP_IDLE);
    go(TAP_IDLE);
  endtask

  // Data scan of n bits, output bits collected in order
  task automatic dr_scan(input int n, input logic [31:0] din, output logic [31:0] dout);
    dout = '0;
    @(posedge tck);
    go(TAP_IDLE);
    go(TAP_SEL_DR);
    go(TAP_CAPTURE_DR);
    go(TAP_SHIFT_DR);
    for (int i = 0; i < n; i++) begin
      // Enum arguments passed whole, never through a conditional
      if (i == n - 1) begin
        go(TAP_EXIT1_DR, din[i]);
      end else begin
        go(TAP_SHIFT_DR, din[i]);
      end
      dout[i] = tdo;
    end
    go(TAP_UPDATE_DR);
    go(TAP_IDLE);
    go(TAP_IDLE);
  endtask
endmodule

// file: tb/jtag_instruction_register_decode_tb_top.sv
// Self-checking bench for the instruction register and decode block
`timescale 1ns/1ps

module jtag_instruction_register_decode_tb_top;
  import jir_pkg::*;
  // ----
  // Signals
  // ----
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic trst_n = 1'b1;
  logic tck, tdi, tdo_q, tdo_oe_q, sel_bsr_q, sel_id_q, sel_byp_q;
  logic bsr_capture_q, bsr_shift_q, bsr_update_q;
  logic pin_latch_q, pin_highz_q, sys_pin_latch_q, sys_pin_highz_q;
  logic [IR_W-1:0] ir_current_q;
  jir_tap_type tap_next;
  int num_errors = 0;
  int checks_done = 0;
  int n_cap, n_sh, n_upd, n_oe;
  // Chain stand-in inverts the input, so its path differs from bypass
  wire logic bsr_so = ~tdi;
  // Identification stand-in echoes the input, so a stuck path shows
  wire logic id_so = tdi;

  always #5 clk_sys = ~clk_sys;

  // Tallies taken mid-cycle, where registered strobes are settled
  always @(negedge tck) begin
    if (bsr_capture_q === 1'b1) n_cap++;
    if (bsr_shift_q === 1'b1) n_sh++;
    if (bsr_update_q === 1'b1) n_upd++;
    if (tdo_oe_q === 1'b1) n_oe++;
  end

  jir_tester tester (.tck(tck), .tap_next(tap_next), .tdi(tdi), .tdo(tdo_q));
  jir_core DUT (.clk_sys, .sys_rst, .tck, .trst_n, .tdi, .tap_next, .bsr_so, .id_so, .tdo_q, .tdo_oe_q,
    .ir_current_q, .sel_bsr_q, .sel_id_q, .sel_byp_q, .bsr_capture_q, .bsr_shift_q, .bsr_update_q,
    .pin_latch_q, .pin_highz_q, .sys_pin_latch_q, .sys_pin_highz_q);

  // ----
  // Helpers
  // ----
  function automatic logic [4:0] dec_now();
    return {sel_bsr_q, sel_id_q, sel_byp_q, pin_latch_q, pin_highz_q};
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic load(input logic [5:0] op);
    logic [5:0] c;
    tester.ir_shift(op, c);
    tester.ir_update();
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_reset();
    logic [31:0] d;
    chk("reset ir", OP_IDCODE, ir_current_q);
    chk("reset path", 5'h08, dec_now());
    tester.dr_scan(8, 32'h0000_00a5, d);
    chk("id path", 32'h0000_00a5, d);
    $display("t_reset done");
  endtask

  // Old instruction holds until update; bypass bit captures zero
  task automatic t_ir_load();
    logic [5:0] c;
    logic [31:0] d;
    tester.ir_shift(OP_BYPASS, c);
    chk("capture out", IR_CAPTURE_PATTERN, c);
    chk("before update", OP_IDCODE, ir_current_q);
    tester.ir_update();
    chk("after update", OP_BYPASS, ir_current_q);
    tester.dr_scan(8, 32'h0000_00a5, d);
    chk("bypass path", 32'h0000_004a, d);
    $display("t_ir_load done");
  endtask

  // Preload comes before the driving mode; reserved codes tried on purpose
  task automatic t_opcodes();
    logic [31:0] d;
    logic [5:0] ops [12] = '{OP_SAMPLE, OP_EXTEST, OP_IDCODE, OP_HIGHZ, OP_CLAMP, OP_BYPASS,
      6'h04, 6'h20, 6'h10, 6'h2c, 6'h2e, 6'h3d};
    logic [4:0] exps [12] = '{5'h10, 5'h12, 5'h08, 5'h05, 5'h06, 5'h04,
      5'h04, 5'h04, 5'h04, 5'h04, 5'h04, 5'h04};
    logic [15:0] tally; // Capture, shift, update and enable counts
    for (int k = 0; k < 12; k++) begin
      load(ops[k]);
      chk("decode", exps[k], dec_now());
      repeat (3) @(posedge clk_sys);
      chk("sys pins", exps[k][1:0], {sys_pin_latch_q, sys_pin_highz_q});
      n_cap = 0;
      n_sh = 0;
      n_upd = 0;
      n_oe = 0;
      tester.dr_scan(8, 32'h0000_00a5, d);
      chk("dr data", exps[k][4] ? 32'h0000_005a : exps[k][3] ? 32'h0000_00a5 : 32'h0000_004a, d);
      tally = {n_cap[3:0], n_sh[3:0], n_upd[3:0], n_oe[3:0]};
      chk("strobes", exps[k][4] ? 16'h1818 : 16'h0008, tally);
    end
    $display("t_opcodes done");
  endtask

  // Mode-select walk, test reset and system reset each restore identification
  task automatic t_resets();
    load(OP_BYPASS);
    tester.go(TAP_SEL_DR);
    tester.go(TAP_SEL_IR);
    tester.go(TAP_TLR);
    tester.go(TAP_TLR);
    tester.go(TAP_IDLE);
    tester.go(TAP_IDLE);
    chk("walk reset", OP_IDCODE, ir_current_q);
    load(OP_CLAMP);
    @(posedge clk_sys);
    trst_n <= 1'b0;
    @(posedge clk_sys);
    chk("test reset", 5'h08, dec_now());
    trst_n <= 1'b1;
    load(OP_EXTEST);
    repeat (3) @(posedge clk_sys);
    chk("sys latch", 1'b1, sys_pin_latch_q);
    sys_rst <= 1'b1;
    @(posedge clk_sys);
    chk("sys reset", {OP_IDCODE, 1'b0}, {ir_current_q, sys_pin_latch_q});
    sys_rst <= 1'b0;
    $display("t_resets done");
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Whole run needs well under 30 us
  initial begin
    #100us;
    num_errors++;
    test_done();
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    t_ir_load();
    t_opcodes();
    t_resets();
    test_done();
  end
endmodule
